// File: rtl/tac_params.svh
`ifndef TAC_PARAMS_SVH
`define TAC_PARAMS_SVH
// Register offsets (8-bit register space)
`define TAC_OFF_CTRL2 8'h37
`define TAC_OFF_CTRL1 8'h36
`define TAC_OFF_CFG 8'h40
`define TAC_OFF_STATUS 8'h41
// Field positions in the interval control register
`define TAC_LOC_LSB 3
`define TAC_LOC_MSB 5
`define TAC_R1_LSB 0
`define TAC_R1_MSB 2
`define TAC_R2_LSB 6
`define TAC_R2_MSB 7
// Field positions in the neighbouring register
`define TAC_R2TOP_BIT 0
`define TAC_EN_R1_BIT 5
`define TAC_EN_LOC_BIT 6
`define TAC_EN_R2_BIT 7
// Configuration register bits
`define TAC_LOCK_BIT 1
// Reset values
`define TAC_CTRL2_RST 8'h00
`define TAC_CTRL1_RST 8'h00
`define TAC_CFG_RST 8'h00
`define TAC_RDATA_IDLE 8'h00
// Interval counter constants
`define TAC_CNT_ZERO 12'h000
`define TAC_CNT_STEP 12'h001
// Base intervals for code 000, in monitoring cycles
`define TAC_DEC_BASE 12'h008
`define TAC_INC_BASE 12'h010
`endif

// File: rtl/tac_pkg.sv
`default_nettype none
package tac_pkg;
   typedef logic [7:0] tac_byte_t;
   typedef logic [2:0] tac_code_t;
   typedef logic [11:0] tac_count_t;
   typedef enum logic [1:0] {
      TAC_HOLD = 2'b00,
      TAC_DOWN = 2'b01,
      TAC_UP = 2'b10
   } tac_step_t;
endpackage
`default_nettype wire

// File: rtl/tac_interval_ctrl.sv
// How it works
// - Local code sits in bits 5:3
// - Local code counts monitoring cycles between adjustments
// - Code 000 gives 8/16, each doubles
// - Remote 2 low bits in 7:6
// - Remote 2 top bit from register 0x36
// - Remote 2 code spaces its adjustments
// - Remote 1 code sits in bits 2:0
// - Lock bit makes register read-only
// - Adjust only while channel enable set
//
// Local design decisions: the register offsets and strobed register access.
`include "tac_params.svh"
`default_nettype none
module tac_interval_ctrl #(
   parameter int CHANNELS = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // Register port
   input wire tac_pkg::tac_byte_t reg_addr,
   input wire tac_pkg::tac_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output var tac_pkg::tac_byte_t reg_rdata,
   // Monitoring engine: one pulse per completed monitoring cycle
   input wire logic monitor_tick,
   // Control loop requests, one per channel (0 local, 1 remote1, 2 remote2)
   input wire logic [2:0] want_decrease,
   input wire logic [2:0] want_increase,
   // Granted threshold adjustments, one-cycle pulses
   output var logic [2:0] do_decrease,
   output var logic [2:0] do_increase
);
   import tac_pkg::*;

   // ------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------
   // Port widths and the channel map are fixed at three channels
   if (CHANNELS != 3) begin : g_bad_channels
      $error("tac_interval_ctrl serves exactly three channels");
   end

   // ------------------------------------------------
   // Helper functions
   // ------------------------------------------------
   // Interval from a three-bit code: base shifted left by code
   function automatic tac_count_t interval(input tac_count_t base, input tac_code_t code);
      interval = tac_count_t'(base << code);
   endfunction

   // True when a counter has reached the given interval
   function automatic logic elapsed(input tac_count_t count, input tac_count_t span);
      elapsed = (count >= span);
   endfunction

   // True when the bus address selects the given register
   function automatic logic addr_hit(input tac_byte_t addr, input tac_byte_t offset);
      addr_hit = (addr == offset);
   endfunction

   // ------------------------------------------------
   // Register write decode
   // ------------------------------------------------
   tac_byte_t ctrl2_ff;
   tac_byte_t nxt_ctrl2;
   tac_byte_t ctrl1_ff;
   tac_byte_t nxt_ctrl1;
   tac_byte_t cfg_ff;
   tac_byte_t nxt_cfg;
   logic locked;
   logic wr_ok;
   logic wr_ctrl2;
   logic wr_ctrl1;
   logic wr_cfg;

   // The lock covers the configuration register too, so it holds until reset
   assign locked = cfg_ff[`TAC_LOCK_BIT];
   assign wr_ok = reg_wr && !locked;
   assign wr_ctrl2 = wr_ok && addr_hit(reg_addr, `TAC_OFF_CTRL2);
   assign wr_ctrl1 = wr_ok && addr_hit(reg_addr, `TAC_OFF_CTRL1);
   assign wr_cfg = wr_ok && addr_hit(reg_addr, `TAC_OFF_CFG);

   // ------------------------------------------------
   // Interval control register
   // ------------------------------------------------
   always_comb begin
      nxt_ctrl2 = ctrl2_ff;
      if (wr_ctrl2) begin
         nxt_ctrl2 = reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl2_ff <= `TAC_CTRL2_RST;
      end else if (clk_en) begin
         ctrl2_ff <= nxt_ctrl2;
      end
   end

   // ------------------------------------------------
   // Neighbouring register: remote 2 top bit and enables
   // ------------------------------------------------
   always_comb begin
      nxt_ctrl1 = ctrl1_ff;
      if (wr_ctrl1) begin
         nxt_ctrl1 = reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl1_ff <= `TAC_CTRL1_RST;
      end else if (clk_en) begin
         ctrl1_ff <= nxt_ctrl1;
      end
   end

   // ------------------------------------------------
   // Configuration register
   // ------------------------------------------------
   always_comb begin
      nxt_cfg = cfg_ff;
      if (wr_cfg) begin
         nxt_cfg = reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_ff <= `TAC_CFG_RST;
      end else if (clk_en) begin
         cfg_ff <= nxt_cfg;
      end
   end

   // ------------------------------------------------
   // Register read
   // ------------------------------------------------
   tac_byte_t rdata_ff;
   tac_byte_t nxt_rdata;
   tac_byte_t status;

   // Read data stand for one cycle and fall back to idle after it
   always_comb begin
      nxt_rdata = `TAC_RDATA_IDLE;
      if (reg_rd) begin
         case (reg_addr)
            `TAC_OFF_CTRL2: begin
               nxt_rdata = ctrl2_ff;
            end
            `TAC_OFF_CTRL1: begin
               nxt_rdata = ctrl1_ff;
            end
            `TAC_OFF_CFG: begin
               nxt_rdata = cfg_ff;
            end
            `TAC_OFF_STATUS: begin
               nxt_rdata = status;
            end
            default: begin
               nxt_rdata = `TAC_RDATA_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_ff <= `TAC_RDATA_IDLE;
      end else if (clk_en) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // ------------------------------------------------
   // Channel codes and enables
   // ------------------------------------------------
   tac_code_t local_interval_code;
   tac_code_t remote1_interval_code;
   tac_code_t remote2_interval_code;
   logic [2:0] chan_en;
   tac_code_t code [3];

   // Channel 0 is local, 1 is remote 1, 2 is remote 2
   assign local_interval_code = ctrl2_ff[`TAC_LOC_MSB:`TAC_LOC_LSB];
   assign remote1_interval_code = ctrl2_ff[`TAC_R1_MSB:`TAC_R1_LSB];
   // Top bit of the remote 2 code lives in the neighbouring register
   assign remote2_interval_code = {ctrl1_ff[`TAC_R2TOP_BIT],
                                   ctrl2_ff[`TAC_R2_MSB:`TAC_R2_LSB]};
   assign code[0] = local_interval_code;
   assign code[1] = remote1_interval_code;
   assign code[2] = remote2_interval_code;
   assign chan_en[0] = ctrl1_ff[`TAC_EN_LOC_BIT];
   assign chan_en[1] = ctrl1_ff[`TAC_EN_R1_BIT];
   assign chan_en[2] = ctrl1_ff[`TAC_EN_R2_BIT];

   // ------------------------------------------------
   // Interval spans
   // ------------------------------------------------
   tac_count_t cnt_ff [3];
   tac_count_t nxt_cnt [3];
   tac_step_t step_ff [3];
   tac_step_t nxt_step [3];
   tac_count_t dec_span [3];
   tac_count_t inc_span [3];
   logic [2:0] dec_ok;
   logic [2:0] inc_ok;

   // Both spans double with every step of the code
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         dec_span[i] = interval(`TAC_DEC_BASE, code[i]);
         inc_span[i] = interval(`TAC_INC_BASE, code[i]);
         dec_ok[i] = elapsed(cnt_ff[i], dec_span[i]);
         inc_ok[i] = elapsed(cnt_ff[i], inc_span[i]);
      end
   end

   // ------------------------------------------------
   // Adjustment grants and interval counters
   // ------------------------------------------------
   // Decrease wins over increase when both are asked in one cycle
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         nxt_step[i] = TAC_HOLD;
         if (chan_en[i] && want_decrease[i] && dec_ok[i]) begin
            nxt_step[i] = TAC_DOWN;
         end else if (chan_en[i] && want_increase[i] && inc_ok[i]) begin
            nxt_step[i] = TAC_UP;
         end
      end
   end

   // The count saturates at the increase span, so a long wait never wraps it
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         nxt_cnt[i] = cnt_ff[i];
         if (!chan_en[i] || nxt_step[i] != TAC_HOLD) begin
            nxt_cnt[i] = `TAC_CNT_ZERO;
         end else if (monitor_tick && !inc_ok[i]) begin
            nxt_cnt[i] = cnt_ff[i] + `TAC_CNT_STEP;
         end
      end
   end

   // ------------------------------------------------
   // Registered channel state
   // ------------------------------------------------
   // Grants are registered so that each lasts exactly one cycle
   always_ff @(posedge clk) begin
      for (int i = 0; i < 3; i++) begin
         if (reset) begin
            step_ff[i] <= TAC_HOLD;
         end else if (clk_en) begin
            step_ff[i] <= nxt_step[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < 3; i++) begin
         if (reset) begin
            cnt_ff[i] <= `TAC_CNT_ZERO;
         end else if (clk_en) begin
            cnt_ff[i] <= nxt_cnt[i];
         end
      end
   end

   // ------------------------------------------------
   // Grant outputs
   // ------------------------------------------------
   // Decoded from the registered step, one pulse per grant
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         case (step_ff[i])
            TAC_DOWN: begin
               do_decrease[i] = 1'b1;
               do_increase[i] = 1'b0;
            end
            TAC_UP: begin
               do_decrease[i] = 1'b0;
               do_increase[i] = 1'b1;
            end
            default: begin
               do_decrease[i] = 1'b0;
               do_increase[i] = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------
   // Status
   // ------------------------------------------------
   // Status: which channels have their decrease / increase interval elapsed
   assign status = {1'b0, inc_ok, 1'b0, dec_ok};
endmodule
`default_nettype wire

// File: bench/tac_interval_ctrl_asserts.sv
`default_nettype none
module tac_interval_ctrl_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // Watched ports
   input wire logic reg_rd,
   input wire tac_pkg::tac_byte_t reg_rdata,
   input wire logic monitor_tick,
   input wire logic [2:0] want_decrease,
   input wire logic [2:0] want_increase,
   input wire logic [2:0] do_decrease,
   input wire logic [2:0] do_increase
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || !clk_en);
   // Ticks since the last local grant
   logic [11:0] tick_ff, nxt_tick;
   always_comb nxt_tick = (do_decrease[0] | do_increase[0]) ? 12'(monitor_tick)
      : tick_ff + 12'(monitor_tick);
   always_ff @(posedge clk) tick_ff <= reset ? 12'h000 : (clk_en ? nxt_tick : tick_ff);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside slot");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> (do_decrease | do_increase) == 3'h0) else $error("grant after reset");
   a_dec_cause: assert property ((do_decrease & ~$past(want_decrease)) == 3'h0)
      else $error("decrease not asked");
   a_inc_cause: assert property ((do_increase & ~$past(want_increase)) == 3'h0)
      else $error("increase not asked");
   a_dec_first: assert property ((do_increase & $past(want_decrease)) == 3'h0)
      else $error("increase beat decrease");
   a_pulse_once: assert property ((do_decrease & $past(do_decrease)) == 3'h0)
      else $error("grant held");
   a_dec_gap: assert property (do_decrease[0] |-> tick_ff >= 12'h008)
      else $error("local decrease early");
   a_inc_gap: assert property (do_increase[0] |-> tick_ff >= 12'h010)
      else $error("local increase early");
   c_local_dec: cover property (do_decrease[0]);
   c_local_inc: cover property (do_increase[0]);
   c_remote2: cover property (do_decrease[2]);
endmodule
bind tac_interval_ctrl tac_interval_ctrl_asserts tac_chk (.clk(clk), .reset(reset),
   .clk_en(clk_en), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .monitor_tick(monitor_tick),
   .want_decrease(want_decrease), .want_increase(want_increase),
   .do_decrease(do_decrease), .do_increase(do_increase));
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("ERROR %s exp %0h got %0h", nm, e, a); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import tac_pkg::*;
   logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic monitor_tick = 1'b0;
   logic [5:0] gv;
   tac_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
   logic [2:0] want_decrease = 3'h0, want_increase = 3'h0, do_decrease, do_increase;
   int n_errors = 0, total_checks = 0, n;
   tac_interval_ctrl tac_interval_ctrl_inst (.clk(clk), .reset(reset), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .monitor_tick(monitor_tick), .want_decrease(want_decrease),
      .want_increase(want_increase), .do_decrease(do_decrease), .do_increase(do_increase));
   initial forever #20 clk = ~clk;
   task wr(input tac_byte_t a, input tac_byte_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input tac_byte_t a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rv = reg_rdata;
   endtask
   // Counts ticks, one every fourth cycle, until a grant or the limit
   task meas(input logic [2:0] d, input logic [2:0] u, input int lim);
      n = 0;
      gv = 6'h00;
      want_decrease <= d;
      want_increase <= u;
      for (int i = 0; i < lim * 4 && gv === 6'h00; i++) begin
         @(posedge clk);
         monitor_tick <= (i % 4 == 3);
         n += int'(i % 4 == 3);
         @(negedge clk);
         gv = {do_increase, do_decrease};
      end
      @(posedge clk);
      want_decrease <= 3'h0;
      want_increase <= 3'h0;
      monitor_tick <= 1'b0;
   endtask
   task t_regs;
      wr(8'h37, 8'ha5);
      rd(8'h37);
      `CHK("ctl", 8'ha5, rv)
      wr(8'h36, 8'h01);
      rd(8'h36);
      `CHK("nbr", 8'h01, rv)
      rd(8'h12);
      `CHK("unm", 8'h00, rv)
   endtask
   task t_freeze;
      @(posedge clk);
      clk_en <= 1'b0;
      wr(8'h37, 8'h3c);
      @(posedge clk);
      clk_en <= 1'b1;
      rd(8'h37);
      `CHK("frz", 8'ha5, rv)
   endtask
   task t_local;
      wr(8'h36, 8'h00);
      wr(8'h37, 8'h00);
      wr(8'h36, 8'h40);
      meas(3'h1, 3'h0, 20);
      `CHK("ldec", 8, n)
      meas(3'h0, 3'h1, 40);
      `CHK("linc", 16, n)
      meas(3'h1, 3'h1, 40);
      `CHK("lpri", 6'h01, gv)
      wr(8'h37, 8'h38);
      meas(3'h0, 3'h1, 2100);
      `CHK("lmax", 2048, n)
      meas(3'h2, 3'h0, 40);
      `CHK("off", 40, n)
   endtask
   task t_remote;
      wr(8'h37, 8'h42);
      wr(8'h36, 8'h21);
      meas(3'h2, 3'h0, 40);
      `CHK("r1", 32, n)
      wr(8'h36, 8'ha1);
      meas(3'h4, 3'h0, 300);
      `CHK("r2", 256, n)
      rd(8'h41);
      `CHK("stat", 8'h22, rv)
      wr(8'h40, 8'h02);
      wr(8'h37, 8'h5a);
      rd(8'h37);
      `CHK("lock", 8'h42, rv)
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      wr(8'h37, 8'h5a);
      rd(8'h37);
      `CHK("unlk", 8'h5a, rv)
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_regs;
      t_freeze;
      t_local;
      t_remote;
      end_of_test;
   end
   initial begin
      #800000;
      n_errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
